/* File: rtl/cgp_pin_control.sv */
// Control logic for two general-purpose codec pins, with AXI4-Lite registers,
// interrupt status and mask, and per-pin function routing.
// Assumes pin inputs and codec-side signals are synchronous to aclk; the
// pad cell resolves the pin from gp_out, gp_oe and the pull enables.
`timescale 1ns/1ps

module cgp_pin_control
  import cgp_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Pins, index 0 is pin 1
  input  wire logic [NUM_PINS-1:0] gp_in,
  output logic [NUM_PINS-1:0]      gp_out,
  output logic [NUM_PINS-1:0]      gp_oe,
  output logic [NUM_PINS-1:0]      pullup_en,
  output logic [NUM_PINS-1:0]      pulldown_en,
  // Codec side
  input  wire logic                microphone_bias_current_detect,
  input  wire logic                microphone_bias_short_detect,
  input  wire logic                digital_mic_lr_clock,
  output logic                     digital_mic_data_in,
  output logic                     irq
);

  cgp_pin_ctl_t        pin_ctl_reg [NUM_PINS];
  logic [NUM_PINS-1:0] int_status_reg;
  logic [NUM_PINS-1:0] int_mask_reg;
  logic [NUM_PINS-1:0] asserted;
  logic [NUM_PINS-1:0] filtered;
  logic [NUM_PINS-1:0] in_used;
  logic [NUM_PINS-1:0] in_prev_reg;
  logic [NUM_PINS-1:0] pin_event;
  logic [NUM_PINS-1:0] gp_out_reg;
  logic [NUM_PINS-1:0] gp_oe_reg;
  logic                irq_reg;
  logic                mic_data_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic                aw_held_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                w_held_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;
  logic                wr_fire;
  logic                rd_fire;
  logic                status_read;
  logic [1:0]          drive_req [NUM_PINS];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Register index from a byte address; low two bits ignored
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction

  // True for a mapped word address
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr[ADDR_W-1:10] == '0) &&
           (reg_index(addr) == IDX_PIN1_CONTROL || reg_index(addr) == IDX_PIN2_CONTROL ||
            reg_index(addr) == IDX_INT_STATUS   || reg_index(addr) == IDX_INT_MASK);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) r[7:0]  = new_v[7:0];
    if (strb[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction

  // Drive request {enable, value} for a pin from its function code
  function automatic logic [1:0] fn_drive(input cgp_pin_ctl_t c, input int pin,
                                          input logic irq_v, input logic cur,
                                          input logic shrt, input logic lrclk);
    logic [1:0] d;
    d = 2'b00;
    unique case (c.function_select)
      FN_GP_OUTPUT:    d = {1'b1, c.output_level};
      FN_IRQ_OUTPUT:   d = {1'b1, irq_v};
      FN_BIAS_CURRENT: d = {1'b1, cur};
      FN_BIAS_SHORT:   d = {1'b1, shrt};
      FN_DIGITAL_MIC:  d = (pin == 0) ? {1'b1, lrclk} : 2'b00;
      default:         d = 2'b00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; reserved top bits never store
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_ctl_reg[0] <= PIN_CTL_RESET;
      pin_ctl_reg[1] <= PIN_CTL_RESET;
      int_mask_reg   <= INT_MASK_RESET;
    end
    else if (wr_fire && awaddr_reg[ADDR_W-1:10] == '0)
    begin
      if (reg_index(awaddr_reg) == IDX_PIN1_CONTROL)
        pin_ctl_reg[0] <= merge16(pin_ctl_reg[0], wdata_reg, wstrb_reg) & PIN_CTL_WMASK;
      if (reg_index(awaddr_reg) == IDX_PIN2_CONTROL)
        pin_ctl_reg[1] <= merge16(pin_ctl_reg[1], wdata_reg, wstrb_reg) & PIN_CTL_WMASK;
      if (reg_index(awaddr_reg) == IDX_INT_MASK && wstrb_reg[0])
        int_mask_reg <= wdata_reg[NUM_PINS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one read in flight
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign status_read   = rd_fire && is_mapped(s_axi_araddr) &&
                         reg_index(s_axi_araddr) == IDX_INT_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= '0;
      if (is_mapped(s_axi_araddr))
      begin
        unique case (reg_index(s_axi_araddr))
          IDX_PIN1_CONTROL: rdata_reg <= {16'h0000, pin_ctl_reg[0]};
          IDX_PIN2_CONTROL: rdata_reg <= {16'h0000, pin_ctl_reg[1]};
          IDX_INT_STATUS:   rdata_reg <= {30'h00000000, int_status_reg};
          default:          rdata_reg <= {30'h00000000, int_mask_reg};
        endcase
      end
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning: polarity, then optional debounce
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin_in
    assign asserted[p] = pin_ctl_reg[p].input_polarity ? gp_in[p] : !gp_in[p];

    cgp_debounce u_debounce (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .din      (asserted[p]),
      .dout_reg (filtered[p])
    );

    // Debounce adds latency, so it is bypassed unless asked for
    assign in_used[p] = pin_ctl_reg[p].debounce_enable ? filtered[p] : asserted[p];

    // Level mode raises while asserted; edge mode only on the rising edge
    assign pin_event[p] = (pin_ctl_reg[p].function_select == FN_GP_INPUT) &&
                          in_used[p] &&
                          (!pin_ctl_reg[p].interrupt_trigger_mode || !in_prev_reg[p]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      in_prev_reg <= '0;
    else
      in_prev_reg <= in_used;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by a read; a new event in that cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status_reg <= '0;
    else
      int_status_reg <= (status_read ? '0 : int_status_reg) | pin_event;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(int_status_reg & int_mask_reg);
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Drive request per pin, decoded ahead of the output flops
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
      drive_req[p] = fn_drive(pin_ctl_reg[p], p, irq_reg, microphone_bias_current_detect,
                              microphone_bias_short_detect, digital_mic_lr_clock);
  end

  // Output drive: registered so the pad sees no decode glitches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gp_out_reg <= '0;
      gp_oe_reg  <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        if (pin_ctl_reg[p].direction || !drive_req[p][1])
        begin
          gp_oe_reg[p]  <= 1'b0;
          gp_out_reg[p] <= 1'b0;
        end
        else if (pin_ctl_reg[p].output_drive_type)
        begin
          // Open-drain only pulls low; the high level comes from outside
          gp_oe_reg[p]  <= !drive_req[p][0];
          gp_out_reg[p] <= 1'b0;
        end
        else
        begin
          gp_oe_reg[p]  <= 1'b1;
          gp_out_reg[p] <= drive_req[p][0];
        end
      end
    end
  end

  assign gp_out = gp_out_reg;
  assign gp_oe  = gp_oe_reg;

  // Digital microphone data is taken off pin 2 through one flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mic_data_reg <= 1'b0;
    else
      mic_data_reg <= (pin_ctl_reg[1].function_select == FN_DIGITAL_MIC) && gp_in[1];
  end

  assign digital_mic_data_in = mic_data_reg;

  // Pulls are plain register bits
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pull
    assign pulldown_en[p] = pin_ctl_reg[p].pulldown_enable;
    assign pullup_en[p]   = pin_ctl_reg[p].pullup_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin1_push_pull(logic [5:0] code);
    pin_ctl_reg[0].function_select == code && !pin_ctl_reg[0].direction &&
    !pin_ctl_reg[0].output_drive_type;
  endsequence

  sequence s_pin1_ctl_write;
    wr_fire && reg_index(awaddr_reg) == IDX_PIN1_CONTROL &&
    awaddr_reg[ADDR_W-1:10] == '0 && wstrb_reg[0];
  endsequence

  a_out_level_drive: assert property (s_pin1_push_pull(FN_GP_OUTPUT) |=>
    gp_oe[0] && gp_out[0] == $past(pin_ctl_reg[0].output_level))
    else $error("pin 1 output level not driven");

  a_irq_on_pin: assert property (pin_ctl_reg[1].function_select == FN_IRQ_OUTPUT &&
    !pin_ctl_reg[1].direction && !pin_ctl_reg[1].output_drive_type |=>
    gp_out[1] == $past(irq))
    else $error("pin 2 does not present interrupt");

  a_bias_current_out: assert property (s_pin1_push_pull(FN_BIAS_CURRENT) |=>
    gp_out[0] == $past(microphone_bias_current_detect))
    else $error("bias current indication missing");

  a_bias_short_out: assert property (s_pin1_push_pull(FN_BIAS_SHORT) |=>
    gp_out[0] == $past(microphone_bias_short_detect))
    else $error("bias short indication missing");

  a_lr_clock_out: assert property (s_pin1_push_pull(FN_DIGITAL_MIC) |=>
    gp_oe[0] && gp_out[0] == $past(digital_mic_lr_clock))
    else $error("mic clock not on pin 1");

  a_mic_data_in: assert property (pin_ctl_reg[1].function_select == FN_DIGITAL_MIC |=>
    digital_mic_data_in == $past(gp_in[1]))
    else $error("mic data not taken from pin 2");

  a_reserved_idle: assert property ((pin_ctl_reg[0].function_select == 6'h01 ||
    pin_ctl_reg[0].function_select > FN_DIGITAL_MIC) |=> !gp_oe[0])
    else $error("reserved code drives pin 1");

  a_pull_write: assert property (s_pin1_ctl_write |=>
    pulldown_en[0] == $past(wdata_reg[3]) && pullup_en[0] == $past(wdata_reg[2]))
    else $error("pull enables not updated");

  a_open_drain_low: assert property (pin_ctl_reg[0].output_drive_type |=>
    !(gp_oe[0] && gp_out[0]))
    else $error("open-drain pin driven high");

  a_level_event_raw: assert property (pin_ctl_reg[0].function_select == FN_GP_INPUT &&
    !pin_ctl_reg[0].debounce_enable && !pin_ctl_reg[0].interrupt_trigger_mode &&
    gp_in[0] == pin_ctl_reg[0].input_polarity |=> int_status_reg[0])
    else $error("level event on pin 1 lost");

endmodule // cgp_pin_control

/* File: common/cgp_pkg.sv */
// Package for the two-pin codec GPIO control block: register map, field
// layout, reset values, function codes and timing counts.
// Assumes a 200 MHz control clock and a 32-bit AXI4-Lite register bus.
package cgp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned DEBOUNCE_TIME_NS = 1000;
  // Least time, rounded up to whole cycles
  localparam int unsigned DEBOUNCE_CYCLES  =
    (DEBOUNCE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DEB_CNT_W        = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PIN1_CONTROL = 8'h74;
  localparam logic [7:0]  IDX_PIN2_CONTROL = 8'h75;
  localparam logic [7:0]  IDX_INT_STATUS   = 8'h80;
  localparam logic [7:0]  IDX_INT_MASK     = 8'h81;
  localparam int unsigned ADDR_W           = 12;
  localparam int unsigned NUM_PINS         = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Function select codes
  localparam logic [5:0]  FN_GP_OUTPUT     = 6'h00;
  localparam logic [5:0]  FN_IRQ_OUTPUT    = 6'h02;
  localparam logic [5:0]  FN_GP_INPUT      = 6'h03;
  localparam logic [5:0]  FN_BIAS_CURRENT  = 6'h04;
  localparam logic [5:0]  FN_BIAS_SHORT    = 6'h05;
  localparam logic [5:0]  FN_DIGITAL_MIC   = 6'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Pin control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic [1:0] reserved;
    logic [5:0] function_select;
    logic       direction;
    logic       output_drive_type;
    logic       input_polarity;
    logic       output_level;
    logic       pulldown_enable;
    logic       pullup_enable;
    logic       interrupt_trigger_mode;
    logic       debounce_enable;
  } cgp_pin_ctl_t;

  localparam logic [15:0] PIN_CTL_RESET    = 16'h00A8;
  localparam logic [15:0] PIN_CTL_WMASK    = 16'h3FFF;
  localparam logic [1:0]  INT_MASK_RESET   = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

/* File: rtl/cgp_debounce.sv */
// Debounce filter for one pin input.
// Assumes the input is already synchronous to aclk.
`timescale 1ns/1ps

module cgp_debounce
  import cgp_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Data
  input  wire logic din,
  output logic      dout_reg
);

  logic [DEB_CNT_W-1:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Output changes only after the input differs for the full count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= '0;
      dout_reg  <= 1'b0;
    end
    else if (din == dout_reg)
    begin
      count_reg <= '0;
    end
    else if (count_reg == DEB_CNT_W'(DEBOUNCE_CYCLES - 1))
    begin
      count_reg <= '0;
      dout_reg  <= din;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule // cgp_debounce

/* File: tb/cgp_pin_partner.sv */
// External circuitry on the two pins: resolves each pad level.
// Assumes the bench says what the outside world drives.
`timescale 1ns/1ps

module cgp_pin_partner
  import cgp_pkg::*;
(
  // Clock
  input  wire logic                aclk,
  // Design side of the pads
  input  wire logic [NUM_PINS-1:0] gp_out,
  input  wire logic [NUM_PINS-1:0] gp_oe,
  input  wire logic [NUM_PINS-1:0] pullup_en,
  input  wire logic [NUM_PINS-1:0] pulldown_en,
  // Outside drivers
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_val,
  // Resolved pad level
  output logic [NUM_PINS-1:0]      gp_in
);
  logic [NUM_PINS-1:0] last_reg;

  // A pad with no driver and no pull wanders, so a stale level is never shown
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (gp_oe[i] && ext_en[i])
        gp_in[i] = 1'bx; // Contention
      else if (gp_oe[i])
        gp_in[i] = gp_out[i];
      else if (ext_en[i])
        gp_in[i] = ext_val[i];
      else if (pullup_en[i])
        gp_in[i] = 1'b1;
      else if (pulldown_en[i])
        gp_in[i] = 1'b0;
      else
        gp_in[i] = ~last_reg[i];
    end
  end

  // Last resolved level
  always @(posedge aclk)
    last_reg <= gp_in;
endmodule // cgp_pin_partner

/* File: tb/tb.sv */
// Self-checking bench for the two-pin control block.
// Assumes a 200 MHz clock and the partner model on the pads.
`timescale 1ns/1ps

module tb;
  import cgp_pkg::*;
  localparam logic [ADDR_W-1:0] A1 = {2'b00, IDX_PIN1_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] A2 = {2'b00, IDX_PIN2_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] AS = {2'b00, IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] AM = {2'b00, IDX_INT_MASK, 2'b00};
  localparam int LIMIT = 20000;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, bias_cur, bias_short, lr_clk, mic_dat, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, r, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, gp_in, gp_out, gp_oe, pu_en, pd_en, ext_en, ext_val, ev;
  logic [15:0] cv;
  logic [5:0] codes [9];
  int err_count, n_compared, cyc;

  ////////////////////////////////////////////////////////////
  // Design and pad partner
  cgp_pin_control dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe),
    .pullup_en(pu_en), .pulldown_en(pd_en), .microphone_bias_current_detect(bias_cur),
    .microphone_bias_short_detect(bias_short), .digital_mic_lr_clock(lr_clk),
    .digital_mic_data_in(mic_dat), .irq(irq));
  cgp_pin_partner pads_u (.aclk(aclk), .gp_out(gp_out), .gp_oe(gp_oe),
    .pullup_en(pu_en), .pulldown_en(pd_en), .ext_en(ext_en), .ext_val(ext_val),
    .gp_in(gp_in));

  ////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic close_out;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!ad && awready)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    while (!(ad && wd));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, rdv, rsp);
    chk("rdata", e, rdv);
    chk("rresp", er, rsp);
  endtask

  // Expected {oe, out} of one pin from its control word and sources
  function automatic logic [1:0] exp_drive(input int p, input logic [15:0] c,
                                           input logic iv, cu, sh, lr);
    logic v;
    if (c[7])
      return 2'b00;
    case (c[13:8])
      FN_GP_OUTPUT:    v = c[4];
      FN_IRQ_OUTPUT:   v = iv;
      FN_BIAS_CURRENT: v = cu;
      FN_BIAS_SHORT:   v = sh;
      FN_DIGITAL_MIC:  if (p == 0) v = lr; else return 2'b00;
      default:         return 2'b00;
    endcase
    return c[6] ? {~v, 1'b0} : {1'b1, v};
  endfunction

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    codes = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h3F};
    seed = 32'h02037AF9;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hF;
    {bias_cur, bias_short, lr_clk, ext_en, ext_val} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A1, 32'h0000_00A8, RESP_OKAY);
    rd_chk(A2, 32'h0000_00A8, RESP_OKAY);
    chk("pulldown_en", 2'b11, pd_en);
    chk("pullup_en", 2'b00, pu_en);
    rd_chk(12'h300, 32'h0, RESP_SLVERR);
    wr(12'h300, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(A1, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(A1, 32'h0000_3FFF, RESP_OKAY);
    chk("gp_oe", 2'b00, gp_oe);
    wr(A1, 32'h0000_0004, RESP_OKAY);
    cyc_n(2);
    chk("pullup_en", 2'b01, pu_en);
    chk("pulldown_en", 2'b10, pd_en);
    // Every defined code and reserved 01, 07, 3F on both pins, random drive type, level and sources
    for (int k = 0; k < 9; k++)
      for (int p = 0; p < 2; p++)
      begin
        r = $random(seed);
        cv = {2'b00, codes[k], 1'b0, r[0], 1'b1, r[1], 4'b1000};
        bias_cur <= r[2];
        bias_short <= r[3];
        lr_clk <= r[4];
        ext_val[1] <= r[5];
        // Outside driver joins only once pin 2 has stopped driving, so the pad never fights
        wr(p ? A2 : A1, {16'h0, cv}, RESP_OKAY);
        ext_en[1] <= (p == 1 && codes[k] == FN_DIGITAL_MIC);
        cyc_n(2);
        ev = exp_drive(p, cv, 1'b0, r[2], r[3], r[4]);
        chk("gp_oe", ev[1], gp_oe[p]);
        chk("gp_out", ev[0], gp_out[p]);
        if (p == 1 && codes[k] == FN_DIGITAL_MIC)
          chk("mic data", r[5], mic_dat);
      end
    // Edge input on pin 2, debounced and then raw
    ext_en <= 2'b11;
    ext_val <= 2'b00;
    wr(AM, 32'h3, RESP_OKAY);
    wr(A1, 32'h0000_03A8, RESP_OKAY);
    wr(A2, 32'h0000_03AB, RESP_OKAY);
    cyc_n(250);
    rd(AS, rdv, rsp);
    ext_val[1] <= 1'b1;
    cyc_n(50);
    ext_val[1] <= 1'b0;
    cyc_n(250);
    rd_chk(AS, 32'h0, RESP_OKAY);
    ext_val[1] <= 1'b1;
    cyc_n(300);
    rd_chk(AS, 32'h2, RESP_OKAY);
    wr(A2, 32'h0000_03AA, RESP_OKAY);
    ext_val[1] <= 1'b0;
    cyc_n(3);
    rd(AS, rdv, rsp);
    ext_val[1] <= 1'b1;
    cyc_n(3);
    ext_val[1] <= 1'b0;
    cyc_n(3);
    rd_chk(AS, 32'h2, RESP_OKAY);
    // Pin 1 level, edge and active-low inputs
    ext_val[0] <= 1'b1;
    cyc_n(4);
    chk("irq", 1'b1, irq);
    rd_chk(AS, 32'h1, RESP_OKAY);
    ext_val[0] <= 1'b0;
    cyc_n(4);
    rd(AS, rdv, rsp);
    rd_chk(AS, 32'h0, RESP_OKAY);
    wr(A1, 32'h0000_03AA, RESP_OKAY);
    ext_val[0] <= 1'b1;
    cyc_n(4);
    rd_chk(AS, 32'h1, RESP_OKAY);
    rd_chk(AS, 32'h0, RESP_OKAY);
    wr(A1, 32'h0000_0388, RESP_OKAY);
    rd(AS, rdv, rsp);
    rd_chk(AS, 32'h0, RESP_OKAY);
    ext_val[0] <= 1'b0;
    cyc_n(4);
    rd_chk(AS, 32'h1, RESP_OKAY);
    // Pin 2 as interrupt output, then masked
    ext_en[1] <= 1'b0;
    wr(A2, 32'h0000_0208, RESP_OKAY);
    cyc_n(2);
    chk("gp_oe", 1'b1, gp_oe[1]);
    chk("gp_out", 1'b1, gp_out[1]);
    wr(AM, 32'h0, RESP_OKAY);
    cyc_n(3);
    chk("irq", 1'b0, irq);
    chk("gp_out", 1'b0, gp_out[1]);
    // Low byte lane only: the function field in the high byte keeps its value
    wstrb <= 4'h1;
    wr(A1, 32'h0000_3F00, RESP_OKAY);
    rd_chk(A1, 32'h0000_0300, RESP_OKAY);
    close_out();
  end
endmodule // tb
